// >>> design/slpp_clkdiv.sv
`timescale 1ns/100ps
module slpp_clkdiv (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic run,
    output logic      clk_out
);

    typedef struct packed {
        logic [11:0] cnt;
        logic        lvl;
    } slpp_div_s;

    slpp_div_s st_ff;
    slpp_div_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!run) begin
            nxt_st.cnt = 12'h000;
            nxt_st.lvl = 1'b0;
        end else if (st_ff.cnt == slpp_pkg::SUSPEND_CLOCK_OUT_HALF - 12'h001) begin
            nxt_st.cnt = 12'h000;
            nxt_st.lvl = ~st_ff.lvl;
        end else begin
            nxt_st.cnt = st_ff.cnt + 12'h001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign clk_out = st_ff.lvl;

endmodule : slpp_clkdiv

// >>> design/slpp_pkg.sv
package slpp_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_DSCFG      = 8'h04;
    localparam logic [7:0]  OFS_STATUS     = 8'h08;

    localparam logic [1:0]  IDX_CTRL       = 2'h0;
    localparam logic [1:0]  IDX_DSCFG      = 2'h1;
    localparam logic [1:0]  IDX_STATUS     = 2'h2;
    localparam logic [1:0]  IDX_NONE       = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int          CTRL_REQ_LSB   = 0;
    localparam int          CTRL_DSX_SUP   = 4;
    localparam int          CTRL_ME_ON_SX  = 5;
    localparam int          CTRL_IDLE_OK   = 6;
    localparam int          CTRL_ME_OFF    = 7;
    localparam int          CTRL_ACK_REQ   = 8;
    localparam int          CTRL_SEQ       = 9;
    localparam int          CTRL_NATIVE    = 10;
    localparam logic [31:0] CTRL_MASK      = 32'h0000_07F7;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0000;

    // Requested power state codes
    localparam logic [2:0]  REQ_S0         = 3'h0;
    localparam logic [2:0]  REQ_S0I3       = 3'h1;
    localparam logic [2:0]  REQ_S4         = 3'h2;
    localparam logic [2:0]  REQ_S5         = 3'h3;
    localparam logic [2:0]  REQ_DSX        = 3'h4;

    // Deep sleep configuration fields
    localparam int          DSCFG_AC_PD    = 0;
    localparam int          DSCFG_NWAKE_PD = 1;
    localparam int          DSCFG_PWAKE_PD = 2;
    localparam logic [2:0]  DSCFG_RST      = 3'h0;

    // Status register fields
    localparam int          STS_STATE_LSB  = 0;
    localparam int          STS_IDLE       = 4;
    localparam int          STS_CPU        = 5;
    localparam int          STS_S4         = 6;
    localparam int          STS_S5         = 7;
    localparam int          STS_SHARED     = 8;
    localparam int          STS_WARN_FN    = 9;
    localparam int          STS_RSM_OK     = 10;
    localparam int          STS_DSW_OK     = 11;
    localparam int          STS_RTC_OK     = 12;
    localparam int          STS_AC_IN      = 13;
    localparam int          STS_SYS_PG     = 14;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CLK_HZ         = 250_000_000;
    localparam int          SUSPEND_CLOCK_OUT_HZ      = 32_768;
    localparam logic [11:0] SUSPEND_CLOCK_OUT_HALF    = 12'(CLK_HZ / (2 * SUSPEND_CLOCK_OUT_HZ));

    typedef enum logic [2:0] {ST_INIT, ST_S0, ST_S0I3, ST_S4, ST_S5, ST_DSX} slpp_state_e;

endpackage : slpp_pkg

// >>> design/slpp_sleep_ctrl.sv
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module slpp_sleep_ctrl (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        resume_well_reset_n,
    input  wire logic        deep_well_power_good,
    input  wire logic        rtc_well_reset_n,
    input  wire logic        system_power_good,
    input  wire logic        ac_power_present,
    output logic             ac_power_present_out,
    output logic             ac_power_present_oe,
    output logic             idle_sleep_out_n,
    output logic             cpu_deep_idle_ind,
    output logic             primary_pins_oe,
    output logic             mgmt_powerdown_ack,
    output logic             suspend_warning_n,
    output logic             shared_pin_warn_fn,
    output logic             sleep_state4_out_n,
    output logic             sleep_state5_out_n,
    output logic             suspend_clock_out,
    output logic             ac_pd_en,
    output logic             network_wake_pd_en,
    output logic             pcie_wake_pd_en,
    output logic             net_phy_pd_en,
    output logic             suspend_clock_out_pd_en
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [31:0]               ctrl;
        logic [2:0]                dscfg;
        logic [31:0]               rdata;
        logic                      wr_pend;
        logic [1:0]                widx;
        slpp_pkg::slpp_state_e     pst;
        logic                      idle_n;
        logic                      cpu_ind;
        logic                      s4_n;
        logic                      s5_n;
        logic                      shared_lvl;
        logic                      warn_fn;
        logic                      boot_seen;
        logic                      ac_low;
    } slpp_main_s;

    slpp_main_s st_ff;
    slpp_main_s nxt_st;

    logic [5:0] sync_q;
    logic       rsm_ok;
    logic       dsw_ok;
    logic       rtc_ok;
    logic       ac_in;
    logic       sys_pg;
    logic [2:0] req;
    logic       addr_ok;
    logic [31:0] status;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and suspend clock
    slpp_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({1'b0, system_power_good, ac_power_present, rtc_well_reset_n,
                   deep_well_power_good, resume_well_reset_n}),
        .q       (sync_q)
    );

    assign rsm_ok = sync_q[0];
    assign dsw_ok = sync_q[1];
    assign rtc_ok = sync_q[2];
    assign ac_in  = sync_q[3];
    assign sys_pg = sync_q[4];

    // Driven low while the deep-sleep well is in reset, toggling after
    slpp_clkdiv u_clkdiv (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (dsw_ok),
        .clk_out (suspend_clock_out)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    function automatic logic [1:0] reg_idx(input logic [31:0] a);
        logic [1:0] r;
        r = slpp_pkg::IDX_NONE;
        if (a[31:8] == 24'h000000) begin
            case (a[7:0])
                slpp_pkg::OFS_CTRL:   r = slpp_pkg::IDX_CTRL;
                slpp_pkg::OFS_DSCFG:  r = slpp_pkg::IDX_DSCFG;
                slpp_pkg::OFS_STATUS: r = slpp_pkg::IDX_STATUS;
                default:              r = slpp_pkg::IDX_NONE;
            endcase
        end
        return r;
    endfunction : reg_idx

    assign req     = st_ff.ctrl[slpp_pkg::CTRL_REQ_LSB +: 3];
    assign addr_ok = hsel && htrans[1] && hready;

    always_comb begin
        status = 32'h0000_0000;
        status[slpp_pkg::STS_STATE_LSB +: 3] = st_ff.pst;
        status[slpp_pkg::STS_IDLE]           = st_ff.idle_n;
        status[slpp_pkg::STS_CPU]            = st_ff.cpu_ind;
        status[slpp_pkg::STS_S4]             = st_ff.s4_n;
        status[slpp_pkg::STS_S5]             = st_ff.s5_n;
        status[slpp_pkg::STS_SHARED]         = st_ff.shared_lvl;
        status[slpp_pkg::STS_WARN_FN]        = st_ff.warn_fn;
        status[slpp_pkg::STS_RSM_OK]         = rsm_ok;
        status[slpp_pkg::STS_DSW_OK]         = dsw_ok;
        status[slpp_pkg::STS_RTC_OK]         = rtc_ok;
        status[slpp_pkg::STS_AC_IN]          = ac_in;
        status[slpp_pkg::STS_SYS_PG]         = sys_pg;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt_st = st_ff;

        // Data phase of a write
        nxt_st.wr_pend = 1'b0;
        if (st_ff.wr_pend) begin
            if (st_ff.widx == slpp_pkg::IDX_CTRL) begin
                nxt_st.ctrl = hwdata & slpp_pkg::CTRL_MASK;
            end else if (st_ff.widx == slpp_pkg::IDX_DSCFG) begin
                nxt_st.dscfg = hwdata[2:0];
            end
        end

        // Address phase; read data is captured here
        if (addr_ok) begin
            nxt_st.wr_pend = hwrite;
            nxt_st.widx    = reg_idx(haddr);
            if (!hwrite) begin
                case (reg_idx(haddr))
                    slpp_pkg::IDX_CTRL:   nxt_st.rdata = st_ff.ctrl;
                    slpp_pkg::IDX_DSCFG:  nxt_st.rdata = {29'h0, st_ff.dscfg};
                    slpp_pkg::IDX_STATUS: nxt_st.rdata = status;
                    default:              nxt_st.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Power state machine, held in init while the deep well is in reset
        if (!dsw_ok) begin
            nxt_st.pst = slpp_pkg::ST_INIT;
        end else begin
            case (st_ff.pst)
                slpp_pkg::ST_INIT: begin
                    // Native function only after the platform reports power good
                    if (st_ff.ctrl[slpp_pkg::CTRL_NATIVE] && sys_pg) begin
                        if (req == slpp_pkg::REQ_S0) begin
                            nxt_st.pst = slpp_pkg::ST_S0;
                        end else if (req == slpp_pkg::REQ_S4) begin
                            nxt_st.pst = slpp_pkg::ST_S4;
                        end else begin
                            nxt_st.pst = slpp_pkg::ST_S5;
                        end
                    end
                end
                slpp_pkg::ST_S0, slpp_pkg::ST_S0I3: begin
                    if (req == slpp_pkg::REQ_S0) begin
                        nxt_st.pst = slpp_pkg::ST_S0;
                    end else if (req == slpp_pkg::REQ_S0I3) begin
                        nxt_st.pst = slpp_pkg::ST_S0I3;
                    end else if (req == slpp_pkg::REQ_S4) begin
                        nxt_st.pst = slpp_pkg::ST_S4;
                    end else if (req == slpp_pkg::REQ_S5) begin
                        nxt_st.pst = slpp_pkg::ST_S5;
                    end
                end
                slpp_pkg::ST_S4, slpp_pkg::ST_S5, slpp_pkg::ST_DSX: begin
                    if (req == slpp_pkg::REQ_S0) begin
                        nxt_st.pst = slpp_pkg::ST_S0;
                    end else if (req == slpp_pkg::REQ_S4) begin
                        nxt_st.pst = slpp_pkg::ST_S4;
                    end else if (req == slpp_pkg::REQ_S5) begin
                        nxt_st.pst = slpp_pkg::ST_S5;
                    end else if (req == slpp_pkg::REQ_DSX
                                 && st_ff.ctrl[slpp_pkg::CTRL_DSX_SUP]) begin
                        nxt_st.pst = slpp_pkg::ST_DSX;
                    end
                end
                default: nxt_st.pst = slpp_pkg::ST_INIT;
            endcase
        end

        // Deep-well sleep outputs, registered from the state
        if (!dsw_ok) begin
            nxt_st.s4_n = 1'b0;
            nxt_st.s5_n = 1'b0;
        end else begin
            case (nxt_st.pst)
                slpp_pkg::ST_INIT: begin
                    nxt_st.s4_n = 1'b1;
                    nxt_st.s5_n = 1'b1;
                end
                slpp_pkg::ST_S4: begin
                    nxt_st.s4_n = 1'b0;
                    nxt_st.s5_n = 1'b1;
                end
                slpp_pkg::ST_S5: begin
                    nxt_st.s4_n = 1'b0;
                    nxt_st.s5_n = 1'b0;
                end
                slpp_pkg::ST_DSX: begin
                    nxt_st.s4_n = st_ff.s4_n;
                    nxt_st.s5_n = st_ff.s5_n;
                end
                default: begin
                    nxt_st.s4_n = 1'b1;
                    nxt_st.s5_n = 1'b1;
                end
            endcase
        end

        // Primary-well outputs
        nxt_st.boot_seen = rtc_ok && (st_ff.boot_seen || rsm_ok);
        if (!rsm_ok) begin
            nxt_st.idle_n     = 1'b1;
            nxt_st.cpu_ind    = 1'b1;
            nxt_st.shared_lvl = 1'b0;
            // Function chosen at each boot after the first since RTC reset
            nxt_st.warn_fn    = st_ff.boot_seen && st_ff.ctrl[slpp_pkg::CTRL_DSX_SUP];
        end else begin
            nxt_st.idle_n  = !(nxt_st.pst == slpp_pkg::ST_S0I3
                               && st_ff.ctrl[slpp_pkg::CTRL_IDLE_OK]);
            nxt_st.cpu_ind = nxt_st.idle_n;
            if (st_ff.warn_fn) begin
                nxt_st.shared_lvl = nxt_st.pst == slpp_pkg::ST_S0
                                    || nxt_st.pst == slpp_pkg::ST_S0I3;
            end else begin
                nxt_st.shared_lvl = st_ff.ctrl[slpp_pkg::CTRL_ME_OFF]
                                    && st_ff.ctrl[slpp_pkg::CTRL_ACK_REQ]
                                    && !st_ff.ctrl[slpp_pkg::CTRL_ME_ON_SX];
            end
        end

        nxt_st.ac_low = !dsw_ok && !st_ff.ctrl[slpp_pkg::CTRL_DSX_SUP];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff       <= '0;
            st_ff.ctrl  <= slpp_pkg::CTRL_RST;
            st_ff.dscfg <= slpp_pkg::DSCFG_RST;
            st_ff.pst   <= slpp_pkg::ST_INIT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hrdata               = st_ff.rdata;
    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign ac_power_present_out = 1'b0;
    assign ac_power_present_oe  = st_ff.ac_low;
    assign idle_sleep_out_n     = st_ff.idle_n;
    assign cpu_deep_idle_ind    = st_ff.cpu_ind;
    assign primary_pins_oe      = st_ff.pst != slpp_pkg::ST_DSX;
    assign shared_pin_warn_fn   = st_ff.warn_fn;
    assign mgmt_powerdown_ack   = !st_ff.warn_fn && st_ff.shared_lvl;
    assign suspend_warning_n    = st_ff.warn_fn ? st_ff.shared_lvl : 1'b1;
    assign sleep_state4_out_n   = st_ff.s4_n;
    assign sleep_state5_out_n   = st_ff.s5_n;
    assign ac_pd_en             = st_ff.ctrl[slpp_pkg::CTRL_SEQ]
                                  || (st_ff.pst == slpp_pkg::ST_DSX
                                      && st_ff.dscfg[slpp_pkg::DSCFG_AC_PD]);
    assign network_wake_pd_en   = st_ff.pst == slpp_pkg::ST_DSX
                                  && st_ff.dscfg[slpp_pkg::DSCFG_NWAKE_PD];
    assign pcie_wake_pd_en      = st_ff.pst == slpp_pkg::ST_DSX
                                  && st_ff.dscfg[slpp_pkg::DSCFG_PWAKE_PD];
    assign net_phy_pd_en        = st_ff.ctrl[slpp_pkg::CTRL_SEQ];
    assign suspend_clock_out_pd_en         = st_ff.ctrl[slpp_pkg::CTRL_SEQ];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_s4_low_sx: assert property (dsw_ok && (nxt_st.pst == slpp_pkg::ST_S4
        || nxt_st.pst == slpp_pkg::ST_S5) |=> !sleep_state4_out_n)
        else $error("sleep state 4 output not low in S4 or S5");
    a_s5_high_s4: assert property (dsw_ok && nxt_st.pst == slpp_pkg::ST_S4
        |=> sleep_state5_out_n && st_ff.pst == slpp_pkg::ST_S4)
        else $error("sleep state 5 output not high in S4");
    a_s5_low_s5: assert property (st_ff.pst == slpp_pkg::ST_S5 && $past(dsw_ok)
        |-> !sleep_state5_out_n)
        else $error("sleep state 5 output not low in S5");
    a_idle_drop: assert property (rsm_ok && st_ff.ctrl[slpp_pkg::CTRL_IDLE_OK]
        && nxt_st.pst == slpp_pkg::ST_S0I3 |=> !idle_sleep_out_n && !cpu_deep_idle_ind)
        else $error("idle outputs not low in S0i3");
    a_idle_high_s0: assert property (rsm_ok && nxt_st.pst == slpp_pkg::ST_S0
        |=> idle_sleep_out_n && cpu_deep_idle_ind)
        else $error("idle outputs not high in S0");
    a_dsx_retain: assert property (dsw_ok && st_ff.pst != slpp_pkg::ST_INIT
        && nxt_st.pst == slpp_pkg::ST_DSX
        |=> $stable(sleep_state4_out_n) && $stable(sleep_state5_out_n))
        else $error("sleep outputs changed on deep sleep entry");
    a_ack_zero: assert property (!st_ff.ctrl[slpp_pkg::CTRL_ME_OFF]
        |=> !mgmt_powerdown_ack)
        else $error("power-down acknowledge high while engine on");
    a_ac_low_rst: assert property (!dsw_ok && !st_ff.ctrl[slpp_pkg::CTRL_DSX_SUP]
        |=> ac_power_present_oe && !ac_power_present_out)
        else $error("AC presence not driven low in reset");
    a_dsw_reset: assert property (!dsw_ok
        |=> !sleep_state4_out_n && !sleep_state5_out_n && st_ff.pst == slpp_pkg::ST_INIT)
        else $error("deep well outputs not reset");
    a_seq_pulls: assert property (st_ff.ctrl[slpp_pkg::CTRL_SEQ]
        |-> ac_pd_en && net_phy_pd_en && suspend_clock_out_pd_en)
        else $error("sequencing pull-downs missing");
    a_dsx_pulls: assert property (st_ff.pst != slpp_pkg::ST_DSX
        |-> !network_wake_pd_en && !pcie_wake_pd_en)
        else $error("wake pull-down outside deep sleep");

    c_enter_dsx: cover property (st_ff.pst == slpp_pkg::ST_S5 ##1 st_ff.pst == slpp_pkg::ST_DSX);
    c_s0i3_idle: cover property (st_ff.pst == slpp_pkg::ST_S0I3 && !idle_sleep_out_n);
    c_warn_boot: cover property (shared_pin_warn_fn && rsm_ok);
    c_bus_write: cover property (addr_ok && hwrite ##1 st_ff.wr_pend);

endmodule : slpp_sleep_ctrl

// >>> design/slpp_sync.sv
`timescale 1ns/100ps
module slpp_sync (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [5:0] d,
    output logic      [5:0] q
);

    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
    } slpp_sync_s;

    slpp_sync_s st_ff;
    slpp_sync_s nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.s2;

endmodule : slpp_sync

// >>> dv/slpp_board_model.sv
`timescale 1ns/100ps
module slpp_board_model (
    input  wire logic hclk,
    input  wire logic wells_up,
    input  wire logic rsm_hold,
    input  wire logic ac_oe,
    output logic      resume_well_reset_n,
    output logic      deep_well_power_good,
    output logic      rtc_well_reset_n,
    output logic      system_power_good,
    output logic      ac_power_present
);
    logic [3:0] cnt_ff;

    // Wells come up in order: RTC, deep well, resume well, then power good
    always_ff @(posedge hclk) begin
        cnt_ff <= !wells_up ? 4'h0 : (cnt_ff == 4'hF ? cnt_ff : cnt_ff + 4'h1);
    end

    assign rtc_well_reset_n     = wells_up;
    assign deep_well_power_good = wells_up && cnt_ff >= 4'h2;
    // Resume well can be cycled alone while the RTC well stays up
    assign resume_well_reset_n  = wells_up && !rsm_hold && cnt_ff >= 4'h4;
    assign system_power_good    = wells_up && cnt_ff == 4'hF;
    assign ac_power_present     = ac_oe ? 1'b0 : 1'b1;
endmodule : slpp_board_model

// >>> dv/slpp_sleep_ctrl_tb.sv
`timescale 1ns/100ps
module slpp_sleep_ctrl_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        wells_up = 1'b0;
    logic        rsm_hold = 1'b0;
    logic [31:0] hrdata;
    logic        hready, hreadyout, hresp, ac_power_present_oe, ac_power_present_out;
    logic        resume_well_reset_n, deep_well_power_good, rtc_well_reset_n;
    logic        system_power_good, ac_power_present, idle_sleep_out_n, cpu_deep_idle_ind;
    logic        primary_pins_oe, mgmt_powerdown_ack, suspend_warning_n, shared_pin_warn_fn;
    logic        sleep_state4_out_n, sleep_state5_out_n, suspend_clock_out, ac_pd_en;
    logic        network_wake_pd_en, pcie_wake_pd_en, net_phy_pd_en, suspend_clock_out_pd_en;
    logic [31:0] q;
    int          fail_count = 0;
    int          comparisons = 0;

    assign hready = hreadyout;
    always #2 hclk = ~hclk;

    slpp_sleep_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .resume_well_reset_n, .deep_well_power_good,
        .rtc_well_reset_n, .system_power_good, .ac_power_present, .ac_power_present_out,
        .ac_power_present_oe, .idle_sleep_out_n, .cpu_deep_idle_ind, .primary_pins_oe,
        .mgmt_powerdown_ack, .suspend_warning_n, .shared_pin_warn_fn, .sleep_state4_out_n,
        .sleep_state5_out_n, .suspend_clock_out, .ac_pd_en, .network_wake_pd_en,
        .pcie_wake_pd_en, .net_phy_pd_en, .suspend_clock_out_pd_en);

    slpp_board_model board (.hclk, .wells_up, .rsm_hold, .ac_oe(ac_power_present_oe),
        .resume_well_reset_n, .deep_well_power_good, .rtc_well_reset_n,
        .system_power_good, .ac_power_present);

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask : step

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic ctl(input logic [31:0] d);
        xfer(slpp_pkg::OFS_CTRL, 1'b1, d);
        step(2);
    endtask : ctl

    task automatic conclude();
        if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_boot();
        wells_up <= 1'b1;
        step(24);
        chk(sleep_state4_out_n, 1'b1);
        chk(shared_pin_warn_fn, 1'b0);
        ctl(32'h400);
        chk(idle_sleep_out_n, 1'b1);
        chk(cpu_deep_idle_ind, 1'b1);
        chk(primary_pins_oe, 1'b1);
        xfer(slpp_pkg::OFS_STATUS, 1'b0, 32'h0);
        chk(q[2:0], 3'h1);
        xfer(8'h0C, 1'b0, 32'h0);
        chk(q, 32'h0);
    endtask : t_boot

    task automatic t_idle();
        ctl(32'h401);
        chk(idle_sleep_out_n, 1'b1);
        ctl(32'h441);
        chk(idle_sleep_out_n, 1'b0);
        chk(cpu_deep_idle_ind, 1'b0);
        ctl(32'h400);
        chk(idle_sleep_out_n, 1'b1);
    endtask : t_idle

    task automatic t_sx();
        ctl(32'h402);
        chk({sleep_state4_out_n, sleep_state5_out_n}, 2'b01);
        ctl(32'h403);
        chk({sleep_state4_out_n, sleep_state5_out_n}, 2'b00);
    endtask : t_sx

    task automatic t_ack();
        ctl(32'h583);
        chk({mgmt_powerdown_ack, suspend_warning_n}, 2'b11);
        ctl(32'h5A3);
        chk(mgmt_powerdown_ack, 1'b0);
        ctl(32'h503);
        chk(mgmt_powerdown_ack, 1'b0);
        ctl(32'h603);
        chk({ac_pd_en, net_phy_pd_en, suspend_clock_out_pd_en}, 3'b111);
        ctl(32'h403);
        chk(net_phy_pd_en, 1'b0);
    endtask : t_ack

    task automatic t_warn();
        ctl(32'h413);
        rsm_hold <= 1'b1;
        step(6);
        chk({idle_sleep_out_n, mgmt_powerdown_ack}, 2'b10);
        rsm_hold <= 1'b0;
        step(6);
        chk(shared_pin_warn_fn, 1'b1);
        chk({mgmt_powerdown_ack, suspend_warning_n}, 2'b00);
        ctl(32'h410);
        chk(suspend_warning_n, 1'b1);
        step(slpp_pkg::SUSPEND_CLOCK_OUT_HALF);
        chk(suspend_clock_out, 1'b1);
    endtask : t_warn

    task automatic t_dsx();
        ctl(32'h412);
        xfer(slpp_pkg::OFS_DSCFG, 1'b1, 32'h7);
        ctl(32'h414);
        chk({sleep_state4_out_n, sleep_state5_out_n}, 2'b01);
        chk(primary_pins_oe, 1'b0);
        chk({ac_pd_en, network_wake_pd_en, pcie_wake_pd_en}, 3'b111);
        xfer(slpp_pkg::OFS_DSCFG, 1'b1, 32'h0);
        step(2);
        chk({ac_pd_en, network_wake_pd_en, pcie_wake_pd_en}, 3'b000);
        ctl(32'h400);
        wells_up <= 1'b0;
        step(8);
        chk({ac_power_present_oe, ac_power_present_out}, 2'b10);
        chk(sleep_state4_out_n, 1'b0);
        chk(suspend_clock_out, 1'b0);
    endtask : t_dsx

    initial begin
        step(4);
        hresetn <= 1'b1;
        step(1);
        t_boot();
        t_idle();
        t_sx();
        t_ack();
        t_warn();
        t_dsx();
        conclude();
    end

    initial begin
        #40000;
        fail_count++;
        conclude();
    end
endmodule : slpp_sleep_ctrl_tb
